// >>> hdl/haptic_cfg.svh
// Purpose: Offsets, reset values and timing counts of the monitor and
//          wave memory port.
// Assumes: 125 MHz core clock.
// Notes:   Definitions only.
`ifndef HAPTIC_CFG_SVH
`define HAPTIC_CFG_SVH

// Register offsets
`define REG_SUPPLY_MON     8'h21
`define REG_PERIOD_MON     8'h22
`define REG_ADDR_HIGH      8'hFD
`define REG_ADDR_LOW       8'hFE
`define REG_DATA_PORT      8'hFF
`define REG_RESET_VALUE    8'h00
`define UNMAPPED_READ      8'h00

// Bus slave address; value is arbitrary
`define SLAVE_ADDR         7'h5A

// Supply code: volts = code * 5600 mV / 255
`define SUPPLY_FULL_MV     5600
`define SUPPLY_CODE_SPAN   255

// Period code step of 98.46 us, counted in half steps per half period
`define CLK_PERIOD_NS      8
`define PERIOD_STEP_NS     98460
`define HALF_STEP_CYCLES   ((`PERIOD_STEP_NS / 2) / `CLK_PERIOD_NS)
`define CODE_MAX           8'hFF
`define FIFO_DEPTH         8

`endif

// >>> hdl/haptic_pkg.sv
// Purpose: Types of the monitor and wave memory port.
// Assumes: Constants come from haptic_cfg.svh.
// Notes:   One state struct each for the port and the tracker; the FIFO keeps its own.
package haptic_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_REG, ST_REG_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } bus_state_t;

  typedef struct packed {
    bus_state_t  st;
    logic        scl_s1, scl_s2, scl_q;
    logic        sda_s1, sda_s2, sda_q;
    logic        cross_s1, cross_s2;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic        rw;
    logic        mack;
    logic [7:0]  ptr;
    logic        pend;
    logic        sda_oe;
    logic        scl_oe;
    logic [7:0]  supply;
    logic [7:0]  period;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic [7:0]  data_last;
  } port_state_t;

  typedef struct packed {
    logic        prev_cross;
    logic        seen;
    logic [15:0] tick;
    logic [7:0]  half_cnt;
    logic [7:0]  code;
    logic        valid;
    logic        phase;
  } track_state_t;

endpackage

// >>> hdl/wave_fifo.sv
// Purpose: Small FIFO between the data port and the wave memory.
// Assumes: Same clock on both sides.
// Notes:   Ready on the fill side drops only when full.
`timescale 1ns/1ps
module wave_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned IW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [IW-1:0]               wr_idx;
    logic [IW-1:0]               rd_idx;
    logic [IW:0]                 count;
  } fifo_state_t;

  fifo_state_t s, next_s;
  logic        do_push, do_pop;

  assign in_ready_o  = (s.count != DEPTH[IW:0]);
  assign out_valid_o = (s.count != '0);
  assign out_data_o  = s.mem[s.rd_idx];
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;

  always_comb begin
    next_s = s;
    if (do_push) begin
      next_s.mem[s.wr_idx] = in_data_i;
      next_s.wr_idx = (s.wr_idx == IW'(DEPTH - 1)) ? '0 : s.wr_idx + 1'b1;
    end
    if (do_pop) begin
      next_s.rd_idx = (s.rd_idx == IW'(DEPTH - 1)) ? '0 : s.rd_idx + 1'b1;
    end
    next_s.count = s.count + {{IW{1'b0}}, do_push} - {{IW{1'b0}}, do_pop};
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // wave_fifo

// >>> hdl/resonance_tracker.sv
// Purpose: Measures the actuator resonance period from back-EMF crossings.
// Assumes: Crossing comparator already synchronised to core_clk_i.
// Notes:   Period code is half-steps per half period, i.e. steps per period.
`timescale 1ns/1ps
`include "haptic_cfg.svh"
module resonance_tracker
  import haptic_pkg::*;
#(
  parameter int unsigned HALF_STEP = `HALF_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Sense
  input  wire logic       playing_i,
  input  wire logic       cross_i,
  // Result
  output logic [7:0]      period_code_o,
  output logic            code_valid_o,
  output logic            phase_o
);
  track_state_t s, next_s;
  logic         edge_seen;

  assign edge_seen     = (cross_i != s.prev_cross);
  assign period_code_o = s.code;
  assign code_valid_o  = s.valid;
  assign phase_o       = s.phase;

  // no calibration input; tracking is self-contained
  always_comb begin
    next_s = s;
    next_s.prev_cross = cross_i;
    if (!playing_i) begin
      next_s.seen     = 1'b0;
      next_s.valid    = 1'b0;
      next_s.tick     = '0;
      next_s.half_cnt = '0;
    end else if (edge_seen) begin
      // drive flips every crossing; code refreshes on each crossing after the first
      next_s.phase = ~s.phase;
      // first full half cycle locks the period
      if (s.seen) begin
        next_s.code  = s.half_cnt;
        next_s.valid = 1'b1;
      end
      next_s.seen     = 1'b1;
      next_s.tick     = '0;
      next_s.half_cnt = '0;
    end else if (s.tick == 16'(HALF_STEP - 1)) begin
      next_s.tick = '0;
      if (s.half_cnt != `CODE_MAX) begin
        next_s.half_cnt = s.half_cnt + 8'h01;
      end
    end else begin
      next_s.tick = s.tick + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  property p_lock_half_cycle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    playing_i && edge_seen && s.seen |=> code_valid_o;
  endproperty
  a_lock_half_cycle: assert property (p_lock_half_cycle)
    else $error("period not locked after half cycle");

  property p_phase_follows;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    playing_i && edge_seen |=> phase_o != $past(phase_o);
  endproperty
  a_phase_follows: assert property (p_phase_follows)
    else $error("drive phase did not follow crossing");
endmodule // resonance_tracker

// >>> hdl/haptic_monitor_and_wave_ram_port.sv
// Purpose: Two-wire register slave for the supply and period monitors and
//          the indirect wave memory port, plus the motor drive polarity.
// Assumes: Supply code from an ADC on core_clk_i; pins are asynchronous.
// Notes:   Data port writes pass a FIFO; a full FIFO stretches the clock.
`timescale 1ns/1ps
`include "haptic_cfg.svh"

// What this block does
// - Supply code register follows the supply only while a waveform plays.
// - Period code register, 98.46 us per step, measured only while playing.
// - Wave memory address high byte, read/write, resets to zero.
// - Wave memory address low byte, read/write, resets to zero.
// - Data port write stores the byte at high:low address.
// - Each data port byte written advances the address by one, single or burst.
// - Tracker locks onto resonance within half a drive cycle.
// - Tracker follows back-EMF and re-adjusts every cycle.
// - Tracker needs no calibration and ignores level calibration.
// - Rotating mass motor driven differentially, polarity sets direction.
module haptic_monitor_and_wave_ram_port
  import haptic_pkg::*;
#(
  parameter int unsigned HALF_STEP = `HALF_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Two-wire bus, open drain, enable high pulls low
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Playback status and supply measurement
  input  wire logic        playing_i,
  input  wire logic [7:0]  supply_code_i,
  // Actuator
  input  wire logic        actuator_is_lra_i,
  input  wire logic        motor_reverse_i,
  input  wire logic        bemf_cross_i,
  output logic             drive_en_o,
  output logic             drive_p_o,
  output logic             drive_n_o,
  // Wave memory write port
  output logic             ram_wr_valid_o,
  input  wire logic        ram_wr_ready_i,
  output logic [15:0]      ram_wr_addr_o,
  output logic [7:0]       ram_wr_data_o
);
  port_state_t s, next_s;
  logic        rise, fall, start_cond, stop_cond;
  logic        push, fifo_ready, host_wr;
  logic [7:0]  rd_byte;
  logic [23:0] fifo_out;
  logic [7:0]  trk_code;
  logic        trk_valid, trk_phase;

  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input port_state_t st);
    if (a == `REG_SUPPLY_MON) begin
      return st.supply;
    end else if (a == `REG_PERIOD_MON) begin
      return st.period;
    end else if (a == `REG_ADDR_HIGH) begin
      return st.addr_hi;
    end else if (a == `REG_ADDR_LOW) begin
      return st.addr_lo;
    end else if (a == `REG_DATA_PORT) begin
      return st.data_last;
    end else begin
      return `UNMAPPED_READ;
    end
  endfunction

  // Only synchroniser outputs feed the edge detectors
  assign rise       = s.scl_s2 & ~s.scl_q;
  assign fall       = ~s.scl_s2 & s.scl_q;
  assign start_cond = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
  assign stop_cond  = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
  assign rd_byte    = read_reg(s.ptr, s);

  always_comb begin
    next_s = s;
    push = 1'b0;
    host_wr = 1'b0;
    next_s.scl_s1   = scl_i;
    next_s.scl_s2   = s.scl_s1;
    next_s.scl_q    = s.scl_s2;
    next_s.sda_s1   = sda_i;
    next_s.sda_s2   = s.sda_s1;
    next_s.sda_q    = s.sda_s2;
    next_s.cross_s1 = bemf_cross_i;
    next_s.cross_s2 = s.cross_s1;
    if (start_cond) begin
      next_s.st        = ST_DEV;
      next_s.bit_cnt   = 3'h0;
      next_s.byte_done = 1'b0;
      next_s.sda_oe    = 1'b0;
    end else if (stop_cond) begin
      next_s.st     = ST_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        ST_DEV, ST_REG, ST_WR: begin
          if (rise) begin
            next_s.shift   = {s.shift[6:0], s.sda_s2};
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
              next_s.byte_done = 1'b1;
            end
          end
          if ((fall && s.byte_done) || s.pend) begin
            next_s.byte_done = 1'b0;
            if (s.st == ST_DEV) begin
              if (s.shift[7:1] == `SLAVE_ADDR) begin
                next_s.rw     = s.shift[0];
                next_s.sda_oe = 1'b1;
                next_s.st     = ST_DEV_ACK;
              end else begin
                next_s.st = ST_IDLE;
              end
            end else if (s.st == ST_REG) begin
              next_s.ptr    = s.shift;
              next_s.sda_oe = 1'b1;
              next_s.st     = ST_REG_ACK;
            end else if (s.ptr == `REG_DATA_PORT && !fifo_ready) begin
              // burst held off by clock stretching
              next_s.pend   = 1'b1;
              next_s.scl_oe = 1'b1;
            end else begin
              next_s.pend   = 1'b0;
              next_s.scl_oe = 1'b0;
              next_s.sda_oe = 1'b1;
              next_s.st     = ST_WR_ACK;
              host_wr       = 1'b1;
              if (s.ptr == `REG_DATA_PORT) begin
                push = 1'b1;
                next_s.data_last = s.shift;
                // low byte carries into high byte
                {next_s.addr_hi, next_s.addr_lo} =
                  {s.addr_hi, s.addr_lo} + 16'h0001;
              end else begin
                next_s.ptr = s.ptr + 8'h01;
                if (s.ptr == `REG_SUPPLY_MON) begin
                  next_s.supply = s.shift;
                end else if (s.ptr == `REG_PERIOD_MON) begin
                  next_s.period = s.shift;
                end else if (s.ptr == `REG_ADDR_HIGH) begin
                  next_s.addr_hi = s.shift;
                end else if (s.ptr == `REG_ADDR_LOW) begin
                  next_s.addr_lo = s.shift;
                end
              end
            end
          end
        end
        ST_DEV_ACK, ST_REG_ACK, ST_WR_ACK: begin
          if (fall) begin
            next_s.sda_oe  = 1'b0;
            next_s.bit_cnt = 3'h0;
            if (s.st == ST_DEV_ACK && s.rw) begin
              next_s.tx     = rd_byte;
              next_s.sda_oe = ~rd_byte[7];
              next_s.st     = ST_RD;
              if (s.ptr != `REG_DATA_PORT) begin
                next_s.ptr = s.ptr + 8'h01;
              end
            end else if (s.st == ST_DEV_ACK) begin
              next_s.st = ST_REG;
            end else begin
              next_s.st = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (rise) begin
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
              next_s.byte_done = 1'b1;
            end
          end
          if (fall) begin
            if (s.byte_done) begin
              next_s.byte_done = 1'b0;
              next_s.sda_oe    = 1'b0;
              next_s.st        = ST_RD_ACK;
            end else begin
              next_s.tx     = {s.tx[6:0], 1'b0};
              next_s.sda_oe = ~s.tx[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (rise) begin
            next_s.mack = ~s.sda_s2;
          end
          if (fall) begin
            next_s.bit_cnt = 3'h0;
            if (s.mack) begin
              next_s.tx     = rd_byte;
              next_s.sda_oe = ~rd_byte[7];
              next_s.st     = ST_RD;
              if (s.ptr != `REG_DATA_PORT) begin
                next_s.ptr = s.ptr + 8'h01;
              end
            end else begin
              next_s.st = ST_IDLE;
            end
          end
        end
        default: begin
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
    // measurement overrides a host write while playing
    if (playing_i) begin
      next_s.supply = supply_code_i;
    end
    // period only from a locked measurement during playback
    if (playing_i && trk_valid) begin
      next_s.period = trk_code;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.scl_s1   <= 1'b1;
      s.scl_s2   <= 1'b1;
      s.scl_q    <= 1'b1;
      s.sda_s1   <= 1'b1;
      s.sda_s2   <= 1'b1;
      s.sda_q    <= 1'b1;
      s.supply   <= `REG_RESET_VALUE;
      s.period   <= `REG_RESET_VALUE;
      s.addr_hi  <= `REG_RESET_VALUE;
      s.addr_lo  <= `REG_RESET_VALUE;
    end else begin
      s <= next_s;
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = s.scl_oe;
  assign sda_oe_o = s.sda_oe;

  wave_fifo #(
    .WIDTH (24),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({s.addr_hi, s.addr_lo, s.shift}),
    .out_valid_o (ram_wr_valid_o),
    .out_ready_i (ram_wr_ready_i),
    .out_data_o  (fifo_out)
  );
  assign ram_wr_addr_o = fifo_out[23:8];
  assign ram_wr_data_o = fifo_out[7:0];

  resonance_tracker #(
    .HALF_STEP (HALF_STEP)
  ) u_tracker (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .playing_i     (playing_i),
    .cross_i       (s.cross_s2),
    .period_code_o (trk_code),
    .code_valid_o  (trk_valid),
    .phase_o       (trk_phase)
  );

  // differential drive; one side sources while the other sinks
  assign drive_en_o = playing_i;
  assign drive_p_o  = playing_i &
                      (actuator_is_lra_i ? trk_phase : ~motor_reverse_i);
  assign drive_n_o  = playing_i &
                      (actuator_is_lra_i ? ~trk_phase : motor_reverse_i);

  property p_supply_follow;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    playing_i |=> s.supply == $past(supply_code_i);
  endproperty
  a_supply_follow: assert property (p_supply_follow)
    else $error("supply code not updated while playing");

  property p_supply_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !playing_i && !host_wr |=> $stable(s.supply);
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("supply code changed while idle");

  property p_period_load;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    playing_i && trk_valid |=> s.period == $past(trk_code);
  endproperty
  a_period_load: assert property (p_period_load)
    else $error("period code not taken from tracker");

  property p_addr_high_wr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    host_wr && s.ptr == `REG_ADDR_HIGH |=> s.addr_hi == $past(s.shift);
  endproperty
  a_addr_high_wr: assert property (p_addr_high_wr)
    else $error("high address byte not written");

  property p_addr_low_wr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    host_wr && s.ptr == `REG_ADDR_LOW |=> s.addr_lo == $past(s.shift);
  endproperty
  a_addr_low_wr: assert property (p_addr_low_wr)
    else $error("low address byte not written");

  property p_push_taken;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    push |-> fifo_ready ##1 (ram_wr_valid_o && s.data_last == $past(s.shift));
  endproperty
  a_push_taken: assert property (p_push_taken)
    else $error("data port byte not queued for memory");

  property p_addr_advance;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    push |=> {s.addr_hi, s.addr_lo} ==
             $past({s.addr_hi, s.addr_lo}) + 16'h0001;
  endproperty
  a_addr_advance: assert property (p_addr_advance)
    else $error("address did not advance after data byte");

  property p_addr_carry;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    push && s.addr_lo == 8'hFF |=>
      s.addr_lo == 8'h00 && s.addr_hi == $past(s.addr_hi) + 8'h01;
  endproperty
  a_addr_carry: assert property (p_addr_carry)
    else $error("low byte overflow did not carry");

  property p_drive_diff;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    drive_en_o && !actuator_is_lra_i |->
      drive_p_o == !motor_reverse_i && drive_n_o == motor_reverse_i;
  endproperty
  a_drive_diff: assert property (p_drive_diff)
    else $error("motor drive polarity wrong");
endmodule // haptic_monitor_and_wave_ram_port

// >>> test/wave_host_model.sv
// Purpose: Two-wire bus host that loads and reads the device registers.
// Assumes: Bench resolves both lines with pull-ups from all enables.
// Notes:   Waits out clock stretching, bounded so a stuck line cannot hang.
`timescale 1ns/1ps
`include "haptic_cfg.svh"
module wave_host_model (
  // Clock
  input  wire logic core_clk_i,
  // Resolved lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Pull-down enables
  output logic      scl_low_o,
  output logic      sda_low_o
);
  localparam int HALF = 12;
  int   nacks = 0;
  logic ack;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic bit_cycle(input logic b, output logic r);
    int k;
    sda_low_o = ~b;
    wait_clk(HALF);
    scl_low_o = 1'b0;
    k = 0;
    // Device may hold the clock low while its buffer is full
    while (scl_i !== 1'b1 && k < 20000) begin
      wait_clk(1);
      k++;
    end
    wait_clk(HALF);
    r = sda_i;
    scl_low_o = 1'b1;
  endtask
  // Also serves as repeated start, since it frees data before clock
  task automatic start_cond();
    sda_low_o = 1'b0;
    wait_clk(HALF);
    scl_low_o = 1'b0;
    wait_clk(HALF);
    sda_low_o = 1'b1;
    wait_clk(HALF);
    scl_low_o = 1'b1;
  endtask
  task automatic stop_cond();
    sda_low_o = 1'b1;
    wait_clk(HALF);
    scl_low_o = 1'b0;
    wait_clk(HALF);
    sda_low_o = 1'b0;
    wait_clk(HALF);
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
    bit_cycle(1'b1, ack);
    if (ack !== 1'b0) nacks++;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(last, ack);
  endtask
  // address first, then one byte or a burst
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] q[$]);
    start_cond();
    put_byte({`SLAVE_ADDR, 1'b0});
    put_byte(ptr);
    foreach (q[i]) put_byte(q[i]);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    start_cond();
    put_byte({`SLAVE_ADDR, 1'b0});
    put_byte(ptr);
    start_cond();
    put_byte({`SLAVE_ADDR, 1'b1});
    get_byte(1'b1, d);
    stop_cond();
  endtask
endmodule // wave_host_model

// >>> test/haptic_monitor_and_wave_ram_port_bench.sv
// Purpose: Self-checking bench for the monitors and wave memory port.
// Assumes: Short half step of 4 clocks; host model speaks the bus.
// Notes:   Memory side stalls for 3000 clocks, long enough for the buffer to force a stretch.
`timescale 1ns/1ps
`include "haptic_cfg.svh"
module haptic_monitor_and_wave_ram_port_bench;
  localparam int HS = 4;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        play     = 1'b0;
  logic        linear_resonant_actuator      = 1'b0;
  logic        rev      = 1'b0;
  logic        bemf     = 1'b0;
  logic        rdy      = 1'b0;
  logic        stretched = 1'b0;
  logic [7:0]  supply   = 8'h00;
  logic        scl_o, scl_oe, sda_o, sda_oe, h_scl, h_sda;
  logic        drv_en, drv_p, drv_n, wr_valid;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [23:0] exp_q[$];
  wire         scl = ~(h_scl | scl_oe);
  wire         sda = ~(h_sda | sda_oe);
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #4 core_clk = ~core_clk;

  haptic_monitor_and_wave_ram_port #(.HALF_STEP(HS)) DUT (
    .core_clk_i(core_clk), .rst_n_i(rst_n),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .playing_i(play), .supply_code_i(supply),
    .actuator_is_lra_i(linear_resonant_actuator), .motor_reverse_i(rev), .bemf_cross_i(bemf),
    .drive_en_o(drv_en), .drive_p_o(drv_p), .drive_n_o(drv_n),
    .ram_wr_valid_o(wr_valid), .ram_wr_ready_i(rdy),
    .ram_wr_addr_o(wr_addr), .ram_wr_data_o(wr_data));

  wave_host_model host (
    .core_clk_i(core_clk), .scl_i(scl), .sda_i(sda),
    .scl_low_o(h_scl), .sda_low_o(h_sda));

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (scl_oe === 1'b1) stretched <= 1'b1;
    if (wr_valid === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) check(24'h1, 24'h0, "unexpected store");
      else check({wr_addr, wr_data}, exp_q.pop_front(), "store");
    end
    if (cyc == 40000) begin
      n_fail++;
      $display("mismatch at %0t: run did not finish in time", $time);
      give_verdict();
    end
  end

  initial begin
    logic [7:0]  offs[6];
    logic [7:0]  d, a_hi, sup;
    logic [7:0]  q[$];
    logic [15:0] a;
    logic        p0;
    offs = '{8'h21, 8'h22, 8'hFD, 8'hFE, 8'hFF, 8'h30};
    void'($urandom(6));
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (offs[i]) begin
      host.read_reg(offs[i], d);
      check(d, 8'h00, "reset value");
    end
    a_hi = 8'($urandom);
    a = {a_hi, 8'hFD};
    host.write_regs(`REG_ADDR_HIGH, '{a_hi, 8'hFD});
    host.read_reg(`REG_ADDR_HIGH, d);
    check(d, a_hi, "address high");
    host.read_reg(`REG_ADDR_LOW, d);
    check(d, 8'hFD, "address low");
    for (int i = 0; i < 10; i++) begin
      q.push_back(8'($urandom));
      exp_q.push_back({a, q[i]});
      a = a + 16'h0001;
    end
    fork
      host.write_regs(`REG_DATA_PORT, q);
      begin
        repeat (3000) @(posedge core_clk);
        #1 rdy = 1'b1;
      end
    join
    check(stretched, 1'b1, "full buffer stretch");
    repeat (50) @(posedge core_clk);
    check(exp_q.size(), 0, "stores left");
    host.read_reg(`REG_ADDR_HIGH, d);
    check(d, a[15:8], "address high after burst");
    host.read_reg(`REG_ADDR_LOW, d);
    check(d, a[7:0], "address low after burst");
    host.read_reg(`REG_DATA_PORT, d);
    check(d, q[9], "data readback");
    rdy = 1'b0;
    sup = 8'($urandom);
    supply = sup;
    linear_resonant_actuator = 1'b1;
    play = 1'b1;
    for (int i = 0; i < 6; i++) begin
      p0 = drv_p;
      bemf = ~bemf;
      repeat (40) @(posedge core_clk);
      #1;
      check({drv_en, drv_p, drv_n}, {1'b1, ~p0, p0}, "phase flip");
    end
    host.read_reg(`REG_SUPPLY_MON, d);
    check(d, sup, "supply while playing");
    host.read_reg(`REG_PERIOD_MON, d);
    check(d >= 8'(40 / HS - 1) && d <= 8'(40 / HS + 1), 1'b1, "period");
    play = 1'b0;
    supply = ~sup;
    host.read_reg(`REG_SUPPLY_MON, d);
    check(d, sup, "supply held when idle");
    // Monitor stays host writable while nothing plays
    sup = 8'($urandom);
    host.write_regs(`REG_SUPPLY_MON, '{sup});
    host.read_reg(`REG_SUPPLY_MON, d);
    check(d, sup, "supply written when idle");
    linear_resonant_actuator = 1'b0;
    for (int i = 0; i < 2; i++) begin
      rev = i[0];
      play = 1'b1;
      @(posedge core_clk);
      #1 check({drv_en, drv_p, drv_n}, {1'b1, ~rev, rev}, "motor");
      play = 1'b0;
      @(posedge core_clk);
      #1 check({drv_en, drv_p, drv_n}, 3'b000, "motor off");
    end
    check({scl_o, sda_o}, 24'h0, "open drain level");
    check(host.nacks, 0, "missing ack");
    give_verdict();
  end
endmodule // haptic_monitor_and_wave_ram_port_bench
